// ==== design/ebir_entry_reg.sv ====
module ebir_entry_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // write port
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  input wire logic [7:0] wrMask,
  // stored value
  output logic [7:0] value
);
  logic [7:0] valueNext;

  assign valueNext = (value & ~wrMask) | (wrData & wrMask);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      value <= RESET_VALUE;
    end else if (wrEn) begin
      value <= valueNext;
    end
  end
endmodule

// ==== design/ebir_pkg.sv ====
package ebir_pkg;
  // -------------------------------------------------------------------------
  // register offsets (word indices; byte address is offset times four)
  // -------------------------------------------------------------------------
  localparam logic [7:0] EBIR_OFF_IDX13 = 8'h4d;
  localparam logic [7:0] EBIR_OFF_IDX14 = 8'h4e;
  localparam logic [7:0] EBIR_OFF_IDX15 = 8'h4f;
  localparam logic [7:0] EBIR_OFF_APPLIED = 8'h52;
  localparam logic [7:0] EBIR_OFF_ADAPT = 8'h55;
  // -------------------------------------------------------------------------
  // byte addresses of all five registers: printed offsets are not multiples of four
  // -------------------------------------------------------------------------
  localparam logic [9:0] EBIR_ADDR_IDX13 = {EBIR_OFF_IDX13, 2'b00};
  localparam logic [9:0] EBIR_ADDR_IDX14 = {EBIR_OFF_IDX14, 2'b00};
  localparam logic [9:0] EBIR_ADDR_IDX15 = {EBIR_OFF_IDX15, 2'b00};
  localparam logic [9:0] EBIR_ADDR_APPLIED = {EBIR_OFF_APPLIED, 2'b00};
  localparam logic [9:0] EBIR_ADDR_ADAPT = {EBIR_OFF_ADAPT, 2'b00};
  localparam int EBIR_ADDR_W = 10;
  // -------------------------------------------------------------------------
  // reset values and field layout
  // -------------------------------------------------------------------------
  localparam logic [7:0] EBIR_RST_IDX13 = 8'ha5;
  localparam logic [7:0] EBIR_RST_IDX14 = 8'he6;
  localparam logic [7:0] EBIR_RST_IDX15 = 8'hf9;
  localparam logic [7:0] EBIR_RST_APPLIED = 8'h00;
  localparam logic [7:0] EBIR_RST_ADAPT = 8'h00;
  localparam logic [7:0] EBIR_ADAPT_WMASK = 8'h7f;
  localparam int EBIR_ADAPT_RO_BIT = 7;
  localparam int EBIR_ADAPT_INIT_BIT = 1;
  localparam int EBIR_STAGE_W = 2;
  localparam int EBIR_STAGES = 4;
  localparam logic [1:0] EBIR_RESP_OKAY = 2'b00;
  localparam logic [1:0] EBIR_RESP_SLVERR = 2'b10;
endpackage

// ==== design/ebir_regs.sv ====
// Function
// - index 13 entry at 0x4d, resets a5
// - index 14 entry at 0x4e, resets e6
// - index 15 entry at 0x4f, resets f9
// - four two-bit stage fields, stage0 on top
// - read-only applied boost at 0x52
// - adaptation control 0x55, bit7 read-only
module ebir_regs (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ebir_pkg::EBIR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ebir_pkg::EBIR_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // equalizer side
  input wire logic [7:0] appliedBoostValue,
  input wire logic adaptStatus,
  output logic [7:0] idx13Entry,
  output logic [7:0] idx14Entry,
  output logic [7:0] idx15Entry,
  output logic [6:0] adaptControl,
  output logic [1:0] idx13Stage0Boost,
  output logic [1:0] idx13Stage1Boost,
  output logic [1:0] idx13Stage2Boost,
  output logic [1:0] idx13Stage3Boost,
  output logic [1:0] idx14Stage0Boost,
  output logic [1:0] idx14Stage1Boost,
  output logic [1:0] idx14Stage2Boost,
  output logic [1:0] idx14Stage3Boost,
  output logic [1:0] idx15Stage0Boost,
  output logic [1:0] idx15Stage1Boost,
  output logic [1:0] idx15Stage2Boost,
  output logic [1:0] idx15Stage3Boost
);
  import ebir_pkg::*;

  // -------------------------------------------------------------------------
  // write channel capture
  // -------------------------------------------------------------------------
  logic awHeld_reg;
  logic wHeld_reg;
  logic [EBIR_ADDR_W-1:0] awAddr_reg;
  logic [7:0] wData_reg;
  logic wStrb_reg;
  logic [7:0] idx13Val;
  logic [7:0] idx14Val;
  logic [7:0] idx15Val;
  logic [7:0] adaptVal;

  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake = s_axi_wvalid & s_axi_wready;
  wire doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
  wire bDone = s_axi_bvalid & s_axi_bready;

  // a channel is held from its handshake until the register update
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
    end else if (awTake) begin
      awHeld_reg <= 1'b1;
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awAddr_reg <= '0;
    end else if (awTake) begin
      awAddr_reg <= s_axi_awaddr;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wHeld_reg <= 1'b0;
    end else if (wTake) begin
      wHeld_reg <= 1'b1;
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end
  end

  // only byte lane 0 carries register data
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wData_reg <= '0;
      wStrb_reg <= 1'b0;
    end else if (wTake) begin
      wData_reg <= s_axi_wdata[7:0];
      wStrb_reg <= s_axi_wstrb[0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
    end else begin
      s_axi_awready <= ~(awTake | awHeld_reg) | doWrite;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_wready <= ~(wTake | wHeld_reg) | doWrite;
    end
  end

  // -------------------------------------------------------------------------
  // write decode
  // -------------------------------------------------------------------------
  wire wAddrWord = awAddr_reg[1:0] == 2'b00;
  wire hitW13 = wAddrWord && awAddr_reg == EBIR_ADDR_IDX13;
  wire hitW14 = wAddrWord && awAddr_reg == EBIR_ADDR_IDX14;
  wire hitW15 = wAddrWord && awAddr_reg == EBIR_ADDR_IDX15;
  wire hitWApplied = wAddrWord && awAddr_reg == EBIR_ADDR_APPLIED;
  wire hitWAdapt = wAddrWord && awAddr_reg == EBIR_ADDR_ADAPT;
  wire wMapped = hitW13 | hitW14 | hitW15 | hitWApplied | hitWAdapt;
  wire wLaneOn = doWrite & wStrb_reg;
  wire [7:0] fullMask = 8'hff;

  // entries are full-width read/write
  ebir_entry_reg #(.RESET_VALUE(EBIR_RST_IDX13)) u_idx13 (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(wLaneOn & hitW13),
    .wrData(wData_reg),
    .wrMask(fullMask),
    .value(idx13Val)
  );
  ebir_entry_reg #(.RESET_VALUE(EBIR_RST_IDX14)) u_idx14 (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(wLaneOn & hitW14),
    .wrData(wData_reg),
    .wrMask(fullMask),
    .value(idx14Val)
  );
  ebir_entry_reg #(.RESET_VALUE(EBIR_RST_IDX15)) u_idx15 (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(wLaneOn & hitW15),
    .wrData(wData_reg),
    .wrMask(fullMask),
    .value(idx15Val)
  );
  // bit 7 is outside the write mask, so software cannot disturb it
  ebir_entry_reg #(.RESET_VALUE(EBIR_RST_ADAPT)) u_adapt (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(wLaneOn & hitWAdapt),
    .wrData(wData_reg),
    .wrMask(EBIR_ADAPT_WMASK),
    .value(adaptVal)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
    end else if (bDone) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // unmapped writes are answered with an error and change nothing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bresp <= EBIR_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bresp <= wMapped ? EBIR_RESP_OKAY : EBIR_RESP_SLVERR;
    end
  end

  // -------------------------------------------------------------------------
  // equalizer-side status sampling
  // -------------------------------------------------------------------------
  logic [7:0] appliedSync1_reg;
  logic [7:0] appliedSync2_reg;
  logic [7:0] appliedSync3_reg;
  logic [7:0] appliedBoost_reg;
  logic statSync1_reg;
  logic adaptStatus_reg;

  // the boost word crosses domains bit by bit, so a value is only
  // taken once two successive synchronised samples agree
  wire appliedSteady = appliedSync2_reg == appliedSync3_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      appliedSync1_reg <= EBIR_RST_APPLIED;
      appliedSync2_reg <= EBIR_RST_APPLIED;
      appliedSync3_reg <= EBIR_RST_APPLIED;
    end else begin
      appliedSync1_reg <= appliedBoostValue;
      appliedSync2_reg <= appliedSync1_reg;
      appliedSync3_reg <= appliedSync2_reg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      appliedBoost_reg <= EBIR_RST_APPLIED;
    end else if (appliedSteady) begin
      appliedBoost_reg <= appliedSync3_reg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      statSync1_reg <= 1'b0;
      adaptStatus_reg <= 1'b0;
    end else begin
      statSync1_reg <= adaptStatus;
      adaptStatus_reg <= statSync1_reg;
    end
  end

  // -------------------------------------------------------------------------
  // read path
  // -------------------------------------------------------------------------
  wire rAddrWord = s_axi_araddr[1:0] == 2'b00;
  wire hitR13 = rAddrWord && s_axi_araddr == EBIR_ADDR_IDX13;
  wire hitR14 = rAddrWord && s_axi_araddr == EBIR_ADDR_IDX14;
  wire hitR15 = rAddrWord && s_axi_araddr == EBIR_ADDR_IDX15;
  wire hitRApplied = rAddrWord && s_axi_araddr == EBIR_ADDR_APPLIED;
  wire hitRAdapt = rAddrWord && s_axi_araddr == EBIR_ADDR_ADAPT;
  wire rMapped = hitR13 | hitR14 | hitR15 | hitRApplied | hitRAdapt;
  wire [7:0] adaptRead = {adaptStatus_reg, adaptVal[EBIR_ADAPT_RO_BIT-1:0]};
  wire [7:0] rByte = ({8{hitR13}} & idx13Val)
                   | ({8{hitR14}} & idx14Val)
                   | ({8{hitR15}} & idx15Val)
                   | ({8{hitRApplied}} & appliedBoost_reg)
                   | ({8{hitRAdapt}} & adaptRead);
  wire arTake = s_axi_arvalid & s_axi_arready;
  wire rDone = s_axi_rvalid & s_axi_rready;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= EBIR_RESP_OKAY;
    end else if (arTake) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rByte};
      s_axi_rresp <= rMapped ? EBIR_RESP_OKAY : EBIR_RESP_SLVERR;
    end else if (rDone) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // one read at a time: no new address while an answer stands
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
    end else if (arTake) begin
      s_axi_arready <= 1'b0;
    end else if (rDone) begin
      s_axi_arready <= 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // outputs to the equalizer, registered
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idx13Entry <= EBIR_RST_IDX13;
      idx14Entry <= EBIR_RST_IDX14;
      idx15Entry <= EBIR_RST_IDX15;
      adaptControl <= EBIR_RST_ADAPT[EBIR_ADAPT_RO_BIT-1:0];
    end else begin
      idx13Entry <= idx13Val;
      idx14Entry <= idx14Val;
      idx15Entry <= idx15Val;
      // bit 1 stays low until software initialises it
      adaptControl <= adaptVal[EBIR_ADAPT_RO_BIT-1:0];
    end
  end

  // stage fields split from the registered entries: stage 0 in bits 7:6
  assign {idx13Stage0Boost, idx13Stage1Boost, idx13Stage2Boost, idx13Stage3Boost} = idx13Entry;
  assign {idx14Stage0Boost, idx14Stage1Boost, idx14Stage2Boost, idx14Stage3Boost} = idx14Entry;
  assign {idx15Stage0Boost, idx15Stage1Boost, idx15Stage2Boost, idx15Stage3Boost} = idx15Entry;
endmodule

// ==== testbench/ebir_regs_monitor.sv ====
module ebir_regs_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // register outputs
  input wire logic [7:0] idx13Entry,
  input wire logic [7:0] idx15Entry,
  input wire logic [6:0] adaptControl,
  input wire logic [1:0] idx13Stage0Boost,
  input wire logic [1:0] idx13Stage1Boost,
  input wire logic [1:0] idx13Stage2Boost,
  input wire logic [1:0] idx13Stage3Boost
);
  timeunit 1ns;
  timeprecision 1ns;
  import ebir_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_RESET_VALUES: assert property (
    $fell(rst) |-> idx13Entry == EBIR_RST_IDX13 && idx15Entry == EBIR_RST_IDX15 && adaptControl == 7'h00)
    else $error("entry values wrong after reset");
  AST_STAGE_ORDER: assert property (
    {idx13Stage0Boost, idx13Stage1Boost, idx13Stage2Boost, idx13Stage3Boost} == idx13Entry)
    else $error("stage fields do not match entry");
  AST_ENTRY_QUIET: assert property (
    $changed({idx13Entry, idx15Entry, adaptControl}) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("register output changed without a write");
  AST_AW_BLOCK: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address accepted twice");
  AST_AR_BLOCK: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while answer pending");
  AST_READ_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_UPPER: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_B_ONE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  cover property (s_axi_bvalid && s_axi_bresp == EBIR_RESP_SLVERR);
  cover property (s_axi_rvalid && s_axi_rdata[7]);
  cover property ($changed(idx15Entry));
endmodule
bind ebir_regs ebir_regs_monitor i_mon (.core_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rdata, .idx13Entry,
  .idx15Entry, .adaptControl, .idx13Stage0Boost, .idx13Stage1Boost, .idx13Stage2Boost, .idx13Stage3Boost);

// ==== testbench/eq_boost_index_registers_bench.sv ====
module eq_boost_index_registers_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ebir_pkg::*;
  logic core_clk, rst, awv, awr, wv, wr_, bv, bready, arv, arr, rv, rready;
  logic [9:0] awa, ara;
  logic [31:0] wd, rd_;
  logic [3:0] strb;
  logic [1:0] br, rr;
  logic [7:0] boost, e13, e14, e15;
  logic adSt;
  logic [6:0] adCtl;
  logic [1:0] s[12];
  int errCount = 0;
  int comparisons = 0;
  ebir_regs i_dut (.core_clk(core_clk), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_awprot(3'b000), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_wdata(wd),
    .s_axi_wstrb(strb), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_bresp(br), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'b000), .s_axi_rvalid(rv),
    .s_axi_rready(rready), .s_axi_rdata(rd_), .s_axi_rresp(rr), .appliedBoostValue(boost),
    .adaptStatus(adSt), .idx13Entry(e13), .idx14Entry(e14), .idx15Entry(e15), .adaptControl(adCtl),
    .idx13Stage0Boost(s[0]), .idx13Stage1Boost(s[1]), .idx13Stage2Boost(s[2]), .idx13Stage3Boost(s[3]),
    .idx14Stage0Boost(s[4]), .idx14Stage1Boost(s[5]), .idx14Stage2Boost(s[6]), .idx14Stage3Boost(s[7]),
    .idx15Stage0Boost(s[8]), .idx15Stage1Boost(s[9]), .idx15Stage2Boost(s[10]), .idx15Stage3Boost(s[11]));
  // -------------------------------------------------------------------------
  // checking and bus tasks
  // -------------------------------------------------------------------------
  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // address and data offered together, each released once taken
  task automatic wrReg(input logic [9:0] a, input logic [7:0] d, input logic [3:0] st, input logic [1:0] er);
    awa <= a;
    wd <= {24'h000000, d};
    strb <= st;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_) wv <= 1'b0;
    end while (!bv);
    chk("bresp", {30'h0, br}, {30'h0, er});
  endtask
  task automatic rdReg(input logic [9:0] a, input logic [7:0] e, input logic [1:0] er);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    chk("rresp", {30'h0, rr}, {30'h0, er});
    if (er == EBIR_RESP_OKAY) chk("rdata", rd_, {24'h000000, e});
  endtask
  // -------------------------------------------------------------------------
  // clock and watchdog
  // -------------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    errCount++;
    finalReport();
  end
  // -------------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------------
  initial begin
    logic [9:0] ad[3];
    logic [7:0] pat[3];
    ad = '{EBIR_ADDR_IDX13, EBIR_ADDR_IDX14, EBIR_ADDR_IDX15};
    pat = '{8'h1b, 8'he4, 8'h6c};
    {rst, awv, wv, arv, adSt} <= 5'h10;
    {awa, ara, wd, strb, boost} <= '0;
    // responses are always accepted at once
    {bready, rready} <= 2'b11;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rdReg(EBIR_ADDR_IDX13, 8'ha5, EBIR_RESP_OKAY);
    rdReg(EBIR_ADDR_IDX14, 8'he6, EBIR_RESP_OKAY);
    rdReg(EBIR_ADDR_IDX15, 8'hf9, EBIR_RESP_OKAY);
    rdReg(EBIR_ADDR_APPLIED, 8'h00, EBIR_RESP_OKAY);
    rdReg(EBIR_ADDR_ADAPT, 8'h00, EBIR_RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      wrReg(ad[i], pat[i], 4'hf, EBIR_RESP_OKAY);
      rdReg(ad[i], pat[i], EBIR_RESP_OKAY);
      chk("stages", {24'h0, s[4*i], s[4*i+1], s[4*i+2], s[4*i+3]}, {24'h0, pat[i]});
    end
    // upper strobes only: no byte lane reaches the register
    wrReg(EBIR_ADDR_IDX13, 8'hff, 4'he, EBIR_RESP_OKAY);
    rdReg(EBIR_ADDR_IDX13, 8'h1b, EBIR_RESP_OKAY);
    boost <= 8'h3c;
    // let the boost word pass its synchroniser and settle
    repeat (3) @(posedge core_clk);
    wrReg(EBIR_ADDR_APPLIED, 8'hff, 4'hf, EBIR_RESP_OKAY);
    rdReg(EBIR_ADDR_APPLIED, 8'h3c, EBIR_RESP_OKAY);
    adSt <= 1'b1;
    wrReg(EBIR_ADDR_ADAPT, 8'h02, 4'hf, EBIR_RESP_OKAY);
    rdReg(EBIR_ADDR_ADAPT, 8'h82, EBIR_RESP_OKAY);
    wrReg(EBIR_ADDR_ADAPT, 8'h7d, 4'hf, EBIR_RESP_OKAY);
    // the control output follows the register one cycle later
    @(posedge core_clk);
    chk("adaptControl", {25'h0, adCtl}, 32'h7d);
    adSt <= 1'b0;
    wrReg(EBIR_ADDR_ADAPT, 8'h80, 4'hf, EBIR_RESP_OKAY);
    rdReg(EBIR_ADDR_ADAPT, 8'h00, EBIR_RESP_OKAY);
    wrReg(10'h150, 8'h55, 4'hf, EBIR_RESP_SLVERR);
    rdReg(10'h150, 8'h00, EBIR_RESP_SLVERR);
    rdReg(EBIR_ADDR_IDX15, 8'h6c, EBIR_RESP_OKAY);
    // second reset in mid-run restores the table
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rdReg(EBIR_ADDR_IDX14, 8'he6, EBIR_RESP_OKAY);
    chk("entries", {8'h00, e13, e14, e15}, {8'h00, EBIR_RST_IDX13, EBIR_RST_IDX14, EBIR_RST_IDX15});
    finalReport();
  end
endmodule
